/* timer_channel.sv */
// one capture/compare/PWM channel slice
// assumes count_i changes only after a step_i cycle
`timescale 1ns/10ps
`default_nettype none
module timer_channel
    import timer_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    // configuration
    input  wire logic [1:0]  mode_sel_i,
    input  wire logic [1:0]  edge_level_i,
    input  wire logic        center_aligned_select_i,
    // counter state
    input  wire logic [15:0] count_i,
    input  wire logic [15:0] value_i,
    input  wire logic        step_i,
    input  wire logic        count_up_i,
    input  wire logic        wrap_i,
    // filtered pin edges
    input  wire logic        pin_rise_i,
    input  wire logic        pin_fall_i,
    // pin drive and events
    output logic             pin_o,
    output logic             pin_oe_o,
    output logic             event_o,
    output logic             capture_o
);
    ch_mode_t mode;
    logic     next_pin;

    always_comb begin
        if (edge_level_i == EL_NONE)
            mode = CH_OFF;
        else if (center_aligned_select_i)
            mode = CH_CPWM;
        else if (mode_sel_i == MS_CAPT)
            mode = CH_CAPTURE;
        else if (mode_sel_i == MS_COMP)
            mode = CH_COMPARE;
        else
            mode = CH_EPWM;
    end

    wire match    = step_i && (count_i == value_i);
    wire set_lvl  = edge_level_i[0];
    wire cap_rise = (edge_level_i == EL_RISE || edge_level_i == EL_BOTH);
    wire cap_fall = (edge_level_i == EL_FALL || edge_level_i == EL_BOTH);
    wire cap_hit  = (pin_rise_i && cap_rise) || (pin_fall_i && cap_fall);

    always_comb begin
        next_pin  = pin_o;
        capture_o = 1'b0;
        event_o   = 1'b0;
        unique case (mode)
            CH_OFF: begin
                next_pin = 1'b0;
            end
            CH_CAPTURE: begin
                capture_o = cap_hit;
                event_o   = cap_hit;
            end
            CH_COMPARE: begin
                if (match) begin
                    event_o = 1'b1;
                    unique case (edge_level_i)
                        EL_RISE: next_pin = ~pin_o;
                        EL_FALL: next_pin = 1'b0;
                        EL_BOTH: next_pin = 1'b1;
                        EL_NONE: next_pin = pin_o;
                    endcase
                end
            end
            CH_EPWM: begin
                if (match) begin
                    event_o  = 1'b1;
                    next_pin = set_lvl;
                end else if (wrap_i) begin
                    next_pin = ~set_lvl;
                end
            end
            CH_CPWM: begin
                if (match) begin
                    event_o  = 1'b1;
                    next_pin = count_up_i ? set_lvl : ~set_lvl;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i)
            pin_o <= 1'b0;
        else
            pin_o <= next_pin;
    end

    assign pin_oe_o = (mode != CH_OFF) && (mode != CH_CAPTURE);
endmodule
`default_nettype wire

/* timer_core.sv */
// 16-bit timer: counter, buffered modulo, six capture/compare channels
// assumes an Avalon-MM master with word addresses and one system clock
// Functional notes
// - overflow flag set as counter leaves modulo
// - modulo byte writes go to a buffer
// - status/control write restarts modulo write sequence
// - debug mode freezes modulo buffer latches
// - debug-mode modulo writes load live register directly
// - modulo high at 3, low at 4
// - six channels at 5 plus three per index
// - edge/level 00 leaves channel pin unused
// - capture mode: rising, falling or both edges
// - compare mode: toggle, clear or set on match
// - edge and center PWM clear or set on match
// - hardware sets channel event flag bit 7
// - flag clears by read then write zero
// - event between read and write keeps flag set
// - channel enable bit 6 gates channel interrupt
// - channel bits 1 and 0 read zero
// - center-aligned select picks up-down counting
`timescale 1ns/10ps
`default_nettype none
module timer_core
    import timer_pkg::*;
(
    // clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] address_i,
    input  wire logic              read_i,
    input  wire logic              write_i,
    input  wire logic [31:0]       writedata_i,
    output logic      [31:0]       readdata_o,
    output logic                   waitrequest_o,
    // debug halt
    input  wire logic              debug_background_mode_i,
    // channel pins
    input  wire logic [NUM_CH-1:0] ch_pin_i,
    output logic      [NUM_CH-1:0] ch_pin_o,
    output logic      [NUM_CH-1:0] ch_pin_oe_o,
    // interrupt
    output logic                   irq_o
);
    // bus handshake: one wait cycle, then the access completes
    // a request still held after its ack pays a fresh wait cycle
    logic        ack;
    wire         req     = read_i | write_i;
    wire         wr_fire = write_i & ack;
    wire         rd_fire = read_i & ack;
    wire [7:0]   wbyte   = writedata_i[7:0];

    assign waitrequest_o = req & ~ack;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i)
            ack <= 1'b0;
        else
            ack <= req & ~ack;
    end

    // channel address decode
    // index and slot mean something only while in_ch is high
    function automatic logic [2:0] ch_index(input logic [4:0] a);
        logic [4:0] off;
        off = a - IDX_CH_BASE;
        ch_index = 3'(off / IDX_CH_STRIDE);
    endfunction

    function automatic logic [1:0] ch_slot(input logic [4:0] a);
        logic [4:0] off;
        off = a - IDX_CH_BASE;
        ch_slot = 2'(off % IDX_CH_STRIDE);
    endfunction

    wire       in_ch   = (address_i >= IDX_CH_BASE) &&
                         (address_i <= IDX_CH_LAST);
    wire [2:0] ch_sel  = ch_index(address_i);
    wire [1:0] ch_part = ch_slot(address_i);

    wire wr_sc    = wr_fire && address_i == IDX_SC;
    wire wr_cnt   = wr_fire && (address_i == IDX_COUNT_HIGH_BYTE ||
                                address_i == IDX_COUNT_LOW_BYTE);
    wire wr_period_limit_high_reg  = wr_fire && address_i == IDX_PERIOD_LIMIT_HIGH_REG;
    wire wr_modl  = wr_fire && address_i == IDX_MODL;
    wire wr_istat = wr_fire && address_i == IDX_IRQ_STAT;
    wire wr_imask = wr_fire && address_i == IDX_IRQ_MASK;
    wire rd_sc    = rd_fire && address_i == IDX_SC;

    // status/control register
    // overflow flag clears by a read while set, then a zero write
    logic [7:0]  sc;
    logic        tof_armed;
    wire         center_aligned_select = sc[SC_CENTER_ALIGNED_SELECT];
    wire         run   = (sc[4:3] != 2'h0) && !debug_background_mode_i;

    // counter
    // counter holds while stopped or halted for debug
    // a zero modulo lets it run over all 16 bits
    logic [15:0] count;
    logic        count_up;
    logic [15:0] mod_live;
    wire  [15:0] top  = (mod_live == 16'h0000) ? CNT_TOP : mod_live;
    wire         at_top = run && count == top;
    wire         wrap   = at_top && !center_aligned_select;
    wire         ovf    = at_top && (!center_aligned_select || count_up);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            count    <= CNT_RST;
            count_up <= 1'b1;
        end else if (wr_cnt) begin
            count    <= CNT_RST;
            count_up <= 1'b1;
        end else if (run) begin
            if (!center_aligned_select) begin
                count    <= wrap ? CNT_RST : count + 16'h0001;
                count_up <= 1'b1;
            end else if (count_up) begin
                count    <= at_top ? count - 16'h0001 : count + 16'h0001;
                count_up <= !at_top;
            end else begin
                count    <= (count == CNT_RST) ? count + 16'h0001
                                               : count - 16'h0001;
                count_up <= (count == CNT_RST);
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sc        <= SC_RST;
            tof_armed <= 1'b0;
        end else begin
            if (wr_sc)
                sc[6:0] <= wbyte[6:0];
            if (ovf) begin
                sc[SC_TOF] <= 1'b1;
                tof_armed  <= 1'b0;
            end else if (wr_sc && tof_armed && !wbyte[SC_TOF]) begin
                sc[SC_TOF] <= 1'b0;
                tof_armed  <= 1'b0;
            end else if (rd_sc && sc[SC_TOF]) begin
                tof_armed  <= 1'b1;
            end
        end
    end

    // modulo: buffered outside debug, direct inside it
    // both bytes must arrive before the live value moves, so the
    // counter never sees half of a new period
    logic [7:0] mod_buf_hi;
    logic [7:0] mod_buf_lo;
    logic       got_hi;
    logic       got_lo;
    wire        dbg = debug_background_mode_i;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mod_buf_hi <= MOD_RST;
            mod_buf_lo <= MOD_RST;
            got_hi     <= 1'b0;
            got_lo     <= 1'b0;
            mod_live   <= {MOD_RST, MOD_RST};
        end else if (wr_sc) begin
            got_hi <= 1'b0;
            got_lo <= 1'b0;
        end else if (dbg) begin
            if (wr_period_limit_high_reg)
                mod_live[15:8] <= wbyte;
            if (wr_modl)
                mod_live[7:0]  <= wbyte;
        end else if (got_hi && got_lo) begin
            mod_live <= {mod_buf_hi, mod_buf_lo};
            got_hi   <= 1'b0;
            got_lo   <= 1'b0;
        end else begin
            if (wr_period_limit_high_reg) begin
                mod_buf_hi <= wbyte;
                got_hi     <= 1'b1;
            end
            if (wr_modl) begin
                mod_buf_lo <= wbyte;
                got_lo     <= 1'b1;
            end
        end
    end
    // while dbg is high the got_* latches keep their entry state unless a status/control write clears them

    // channel pins
    // pin edges arrive three flops late through the synchroniser
    logic [NUM_CH-1:0] pin_lvl;
    logic [NUM_CH-1:0] pin_rise;
    logic [NUM_CH-1:0] pin_fall;

    timer_pin_sync #(
        .W (NUM_CH)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .pin_i     (ch_pin_i),
        .level_o   (pin_lvl),
        .rise_o    (pin_rise),
        .fall_o    (pin_fall)
    );

    // channel registers
    // a new event disarms a pending flag clear, so no request is lost
    logic [7:0]        ch_sc    [NUM_CH];
    logic [15:0]       ch_val   [NUM_CH];
    logic [NUM_CH-1:0] ch_armed;
    logic [NUM_CH-1:0] ch_event;
    logic [NUM_CH-1:0] ch_capt;

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        wire sel    = in_ch && ch_sel == 3'(i);
        wire wr_cs  = wr_fire && sel && ch_part == 2'h0;
        wire wr_vh  = wr_fire && sel && ch_part == 2'h1;
        wire wr_vl  = wr_fire && sel && ch_part == 2'h2;
        wire rd_cs  = rd_fire && sel && ch_part == 2'h0;
        wire clr_ok = wr_cs && ch_armed[i] && !wbyte[CS_FLAG];

        timer_channel u_ch (
            .clk_sys_i               (clk_sys_i),
            .rst_i                   (rst_i),
            .mode_sel_i              (ch_sc[i][CS_MS_HI:CS_MS_LO]),
            .edge_level_i            (ch_sc[i][CS_EL_HI:CS_EL_LO]),
            .center_aligned_select_i (center_aligned_select),
            .count_i                 (count),
            .value_i                 (ch_val[i]),
            .step_i                  (run),
            .count_up_i              (count_up),
            .wrap_i                  (wrap),
            .pin_rise_i              (pin_rise[i]),
            .pin_fall_i              (pin_fall[i]),
            .pin_o                   (ch_pin_o[i]),
            .pin_oe_o                (ch_pin_oe_o[i]),
            .event_o                 (ch_event[i]),
            .capture_o               (ch_capt[i])
        );

        always_ff @(posedge clk_sys_i or posedge rst_i) begin
            if (rst_i) begin
                ch_sc[i]    <= CS_RST;
                ch_armed[i] <= 1'b0;
            end else begin
                if (wr_cs)
                    ch_sc[i][CS_IE:CS_EL_LO] <= wbyte[CS_IE:CS_EL_LO];
                if (ch_event[i]) begin
                    ch_sc[i][CS_FLAG] <= 1'b1;
                    ch_armed[i]       <= 1'b0;
                end else if (clr_ok) begin
                    ch_sc[i][CS_FLAG] <= 1'b0;
                    ch_armed[i]       <= 1'b0;
                end else if (rd_cs && ch_sc[i][CS_FLAG]) begin
                    ch_armed[i]       <= 1'b1;
                end
            end
        end

        always_ff @(posedge clk_sys_i or posedge rst_i) begin
            if (rst_i)
                ch_val[i] <= CV_RST;
            else if (ch_capt[i])
                ch_val[i] <= count;
            else if (wr_vh)
                ch_val[i][15:8] <= wbyte;
            else if (wr_vl)
                ch_val[i][7:0]  <= wbyte;
        end
    end

    // sticky interrupt status, write one to clear, set wins
    // irq_o also needs the per-source enable of each event
    logic [NUM_CH:0] irq_stat;
    logic [NUM_CH:0] irq_mask;
    wire  [NUM_CH:0] irq_set = {ovf, ch_event};
    wire  [NUM_CH:0] irq_clr = wr_istat ? writedata_i[NUM_CH:0] : '0;
    logic [NUM_CH:0] src_en;

    always_comb begin
        src_en[IRQ_OVF] = sc[SC_TOIE];
        for (int k = 0; k < NUM_CH; k++)
            src_en[k] = ch_sc[k][CS_IE];
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            irq_stat <= IRQ_RST;
            irq_mask <= IRQ_RST;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
            if (wr_imask)
                irq_mask <= writedata_i[NUM_CH:0];
        end
    end

    assign irq_o = |(irq_stat & irq_mask & src_en);

    // read data, registered in the wait cycle
    // the byte is latched as the request arrives, so it stands
    // unchanged through the completing cycle
    logic [7:0] ch_rd;
    logic [7:0] next_rd;

    always_comb begin
        unique case (ch_part)
            2'h0:    ch_rd = {ch_sc[ch_sel][7:2], 2'h0};
            2'h1:    ch_rd = ch_val[ch_sel][15:8];
            default: ch_rd = ch_val[ch_sel][7:0];
        endcase
    end

    always_comb begin
        next_rd = 8'h00;
        if (in_ch)
            next_rd = ch_rd;
        else begin
            unique case (address_i)
                IDX_SC:       next_rd = sc;
                IDX_COUNT_HIGH_BYTE:     next_rd = count[15:8];
                IDX_COUNT_LOW_BYTE:     next_rd = count[7:0];
                IDX_PERIOD_LIMIT_HIGH_REG:     next_rd = mod_live[15:8];
                IDX_MODL:     next_rd = mod_live[7:0];
                IDX_IRQ_STAT: next_rd = 8'(irq_stat);
                IDX_IRQ_MASK: next_rd = 8'(irq_mask);
                default:      next_rd = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i)
            readdata_o <= 32'h0000_0000;
        else if (read_i && !ack)
            readdata_o <= {24'h00_0000, next_rd};
    end

    // pin_lvl kept for readback-free filtering; stable level unused here
    wire unused_lvl = ^pin_lvl;
endmodule
`default_nettype wire

/* timer_core_checker.sv */
// port-level checks for the timer core bus and channel pins
// assumes one system clock and the bind at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module timer_core_checker
    import timer_pkg::*;
(
    input wire logic              clk_sys_i,
    input wire logic              rst_i,
    input wire logic [ADDR_W-1:0] address_i,
    input wire logic              read_i,
    input wire logic              write_i,
    input wire logic [31:0]       writedata_i,
    input wire logic [31:0]       readdata_o,
    input wire logic              waitrequest_o,
    input wire logic              debug_background_mode_i,
    input wire logic [NUM_CH-1:0] ch_pin_i,
    input wire logic [NUM_CH-1:0] ch_pin_o,
    input wire logic [NUM_CH-1:0] ch_pin_oe_o,
    input wire logic              irq_o
);
    logic is_cs;
    // address lands on a channel status and control register
    assign is_cs = (address_i >= IDX_CH_BASE) && (address_i <= IDX_CH_LAST)
        && (((address_i - IDX_CH_BASE) % 5'h03) == 5'h00);

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    chk_wait_first: assert property (
        $rose(read_i || write_i) |-> waitrequest_o)
        else $error("no wait cycle on new request");
    chk_wait_one: assert property (
        waitrequest_o |=> !waitrequest_o)
        else $error("wait lasted more than one cycle");
    chk_wait_idle: assert property (
        !(read_i || write_i) |-> !waitrequest_o)
        else $error("wait raised with no request");
    chk_upper_zero: assert property (
        readdata_o[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    chk_rsvd_zero: assert property (
        read_i && !waitrequest_o && is_cs |-> readdata_o[1:0] == 2'h0)
        else $error("channel reserved bits read nonzero");
    chk_rdata_hold: assert property (
        !read_i && !$past(read_i) |-> $stable(readdata_o))
        else $error("read data changed without a read");
    chk_reset_quiet: assert property (
        $fell(rst_i) |-> !irq_o && ch_pin_oe_o == 6'h00)
        else $error("outputs active after reset");
    chk_oe_cause: assert property (
        ch_pin_oe_o != $past(ch_pin_oe_o)
        |-> $past(write_i && !waitrequest_o))
        else $error("pin enable changed without a write");
endmodule

bind timer_core timer_core_checker timer_core_checker_i (
    .clk_sys_i, .rst_i, .address_i, .read_i, .write_i, .writedata_i,
    .readdata_o, .waitrequest_o, .debug_background_mode_i, .ch_pin_i,
    .ch_pin_o, .ch_pin_oe_o, .irq_o
);
`default_nettype wire

/* timer_modulo_and_channel_control_tb_top.sv */
// self-checking bench for timer modulo and channel registers
// assumes timer_pkg, the pin partner and the bound checker
`timescale 1ns/10ps
`default_nettype none
module timer_modulo_and_channel_control_tb_top
    import timer_pkg::*;
;
    logic              clk_sys_i = 1'b0;
    logic              rst_i = 1'b1;
    logic [ADDR_W-1:0] address_i = 5'h00;
    logic              read_i = 1'b0;
    logic              write_i = 1'b0;
    logic [31:0]       writedata_i = 32'h00000000;
    logic [31:0]       readdata_o;
    logic              waitrequest_o;
    logic              debug_background_mode_i = 1'b0;
    logic [NUM_CH-1:0] ext_level = 6'h00;
    logic [NUM_CH-1:0] ch_pin_i;
    logic [NUM_CH-1:0] ch_pin_o;
    logic [NUM_CH-1:0] ch_pin_oe_o;
    logic              irq_o;
    logic [7:0]        q;
    int                fails = 0;
    int                compares = 0;

    timer_core timer_core_i (
        .clk_sys_i, .rst_i, .address_i, .read_i, .write_i, .writedata_i,
        .readdata_o, .waitrequest_o, .debug_background_mode_i, .ch_pin_i,
        .ch_pin_o, .ch_pin_oe_o, .irq_o
    );
    timer_pin_partner timer_pin_partner_i (
        .ext_level_i(ext_level), .drive_i(ch_pin_o),
        .drive_oe_i(ch_pin_oe_o), .pin_o(ch_pin_i)
    );

    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    function automatic logic [4:0] ch_a(input int i);
        return 5'(IDX_CH_BASE + IDX_CH_STRIDE * i);
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one bus access; data taken at the edge where waitrequest is low
    task automatic bus(input logic rd, input logic [4:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        address_i   <= a;
        writedata_i <= {24'h000000, d};
        read_i      <= rd;
        write_i     <= ~rd;
        @(posedge clk_sys_i);
        while (waitrequest_o !== 1'b0 && n < 100) begin
            n++;
            @(posedge clk_sys_i);
        end
        if (n >= 100) begin
            fails++;
            $display("ERROR t=%0t waitrequest=%h exp=%h",
                     $time, waitrequest_o, 1'b0);
        end
        q = readdata_o[7:0];
        read_i  <= 1'b0;
        write_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b0, a, d);
    endtask

    task automatic rc(input logic [4:0] a, input logic [7:0] e);
        bus(1'b1, a, 8'h00);
        chk(q, e);
    endtask

    task automatic t_reset;
        for (int i = 0; i < NUM_CH; i++) begin
            rc(ch_a(i), CS_RST);
        end
        rc(IDX_PERIOD_LIMIT_HIGH_REG, MOD_RST);
        rc(IDX_MODL, MOD_RST);
        rc(5'h1F, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_fields;
        wr(ch_a(1), 8'hFF);
        rc(ch_a(1), 8'h7C);
        wr(ch_a(3), 8'h30);
        chk({7'h00, ch_pin_oe_o[3]}, 8'h00);
        wr(ch_a(1), 8'h00);
        wr(ch_a(3), 8'h00);
        $display("test fields done");
    endtask

    task automatic t_modulo;
        wr(IDX_COUNT_HIGH_BYTE, 8'h00);
        wr(IDX_PERIOD_LIMIT_HIGH_REG, 8'h00);
        wr(IDX_MODL, 8'h20);
        rc(IDX_MODL, 8'h20);
        rc(IDX_PERIOD_LIMIT_HIGH_REG, 8'h00);
        debug_background_mode_i <= 1'b1;
        wr(IDX_MODL, 8'h30);
        rc(IDX_MODL, 8'h30);
        debug_background_mode_i <= 1'b0;
        $display("test modulo done");
    endtask

    task automatic t_compare;
        int n;
        wr(5'h06, 8'h00);
        wr(5'h07, 8'h08);
        wr(IDX_IRQ_MASK, 8'h01);
        wr(ch_a(0), 8'h54);
        wr(IDX_COUNT_LOW_BYTE, 8'h00);
        wr(IDX_SC, 8'h08);
        n = 0;
        while (irq_o !== 1'b1 && n < 200) begin
            @(posedge clk_sys_i);
            n++;
        end
        chk({7'h00, irq_o}, 8'h01);
        chk({6'h00, ch_pin_oe_o[0], ch_pin_o[0]}, 8'h03);
        wr(IDX_SC, 8'h00);
        wr(IDX_IRQ_MASK, 8'h00);
        chk({7'h00, irq_o}, 8'h00);
        wr(IDX_IRQ_MASK, 8'h01);
        chk({7'h00, irq_o}, 8'h01);
        rc(ch_a(0), 8'hD4);
        wr(ch_a(0), 8'h54);
        rc(ch_a(0), 8'h54);
        wr(IDX_IRQ_STAT, 8'h01);
        chk({7'h00, irq_o}, 8'h00);
        $display("test compare done");
    endtask

    task automatic t_capture;
        wr(ch_a(2), 8'h04);
        wr(IDX_SC, 8'h08);
        ext_level[2] <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        rc(ch_a(2), 8'h84);
        wr(ch_a(2), 8'h04);
        rc(ch_a(2), 8'h04);
        ext_level[2] <= 1'b0;
        repeat (8) @(posedge clk_sys_i);
        rc(ch_a(2), 8'h04);
        chk({7'h00, ch_pin_oe_o[2]}, 8'h00);
        $display("test capture done");
    endtask

    task automatic t_overflow;
        int n;
        wr(IDX_SC, 8'h00);
        wr(IDX_PERIOD_LIMIT_HIGH_REG, 8'h00);
        wr(IDX_SC, 8'h00);
        wr(IDX_MODL, 8'h10);
        rc(IDX_MODL, 8'h30);
        wr(IDX_PERIOD_LIMIT_HIGH_REG, 8'h00);
        rc(IDX_MODL, 8'h10);
        wr(5'h12, 8'h00);
        wr(5'h13, 8'h04);
        wr(ch_a(4), 8'h28);
        wr(IDX_COUNT_HIGH_BYTE, 8'h00);
        wr(IDX_SC, 8'h08);
        n = 0;
        while (ch_pin_o[4] !== 1'b1 && n < 100) begin
            @(posedge clk_sys_i);
            n++;
        end
        n = 0;
        while (ch_pin_o[4] === 1'b1 && n < 100) begin
            @(posedge clk_sys_i);
            n++;
        end
        chk(8'(n), 8'h05);
        rc(IDX_SC, 8'h88);
        wr(IDX_SC, 8'h00);
        wr(ch_a(4), 8'h00);
        $display("test overflow done");
    endtask

    task automatic wrap_up;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        fails++;
        wrap_up();
    end

    initial begin
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        t_reset();
        t_fields();
        t_modulo();
        t_compare();
        t_capture();
        t_overflow();
        wrap_up();
    end
endmodule
`default_nettype wire

/* timer_pin_partner.sv */
// outside circuitry on the channel pins
// assumes the timer drives a pin only while its enable is high
`timescale 1ns/10ps
`default_nettype none
module timer_pin_partner
    import timer_pkg::*;
(
    // level the outside world applies
    input  wire logic [NUM_CH-1:0] ext_level_i,
    // timer drive
    input  wire logic [NUM_CH-1:0] drive_i,
    input  wire logic [NUM_CH-1:0] drive_oe_i,
    // resolved pin level
    output logic      [NUM_CH-1:0] pin_o
);
    // an undriven pin follows the outside level
    assign pin_o = (drive_oe_i & drive_i) | (~drive_oe_i & ext_level_i);
endmodule
`default_nettype wire

/* timer_pin_sync.sv */
// three-flop synchroniser with agreement filter for the channel pins
// assumes asynchronous pin levels; emits one-cycle edge pulses
`timescale 1ns/10ps
`default_nettype none
module timer_pin_sync #(
    parameter int W = 6
) (
    // clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         rst_i,
    // pins
    input  wire logic [W-1:0] pin_i,
    // filtered level and edges
    output logic      [W-1:0] level_o,
    output logic      [W-1:0] rise_o,
    output logic      [W-1:0] fall_o
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    wire  [W-1:0] agree = ~(s2 ^ s3);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            s1      <= '0;
            s2      <= '0;
            s3      <= '0;
            level_o <= '0;
        end else begin
            s1      <= pin_i;
            s2      <= s1;
            s3      <= s2;
            level_o <= (agree & s3) | (~agree & level_o);
        end
    end

    assign rise_o = agree & s3 & ~level_o;
    assign fall_o = agree & ~s3 & level_o;
endmodule
`default_nettype wire

/* timer_pkg.sv */
// timer register map, field positions and reset values
// shared by the timer core and its channel slices
package timer_pkg;
    localparam int NUM_CH = 6;
    localparam int ADDR_W = 5;
    // register indices; byte address is four times the index
    localparam logic [4:0] IDX_SC        = 5'h00;
    localparam logic [4:0] IDX_COUNT_HIGH_BYTE      = 5'h01;
    localparam logic [4:0] IDX_COUNT_LOW_BYTE      = 5'h02;
    localparam logic [4:0] IDX_PERIOD_LIMIT_HIGH_REG      = 5'h03;
    localparam logic [4:0] IDX_MODL      = 5'h04;
    localparam logic [4:0] IDX_CH_BASE   = 5'h05;
    localparam logic [4:0] IDX_CH_STRIDE = 5'h03;
    localparam logic [4:0] IDX_CH_LAST   = 5'h16;
    localparam logic [4:0] IDX_IRQ_STAT  = 5'h18;
    localparam logic [4:0] IDX_IRQ_MASK  = 5'h19;
    // timer_status_control fields
    localparam int SC_TOF   = 7;
    localparam int SC_TOIE  = 6;
    localparam int SC_CENTER_ALIGNED_SELECT = 5;
    // channel_status_control fields
    localparam int CS_FLAG  = 7;
    localparam int CS_IE    = 6;
    localparam int CS_MS_HI = 5;
    localparam int CS_MS_LO = 4;
    localparam int CS_EL_HI = 3;
    localparam int CS_EL_LO = 2;
    localparam logic [7:0] CS_RW_MASK = 8'h3C;
    // reset values
    localparam logic [7:0]  SC_RST   = 8'h00;
    localparam logic [7:0]  MOD_RST  = 8'h00;
    localparam logic [7:0]  CS_RST   = 8'h00;
    localparam logic [15:0] CNT_RST  = 16'h0000;
    localparam logic [15:0] CV_RST   = 16'h0000;
    localparam logic [15:0] CNT_TOP  = 16'hFFFF;
    localparam logic [6:0]  IRQ_RST  = 7'h00;
    // interrupt status bit of the overflow event, above the channels
    localparam int IRQ_OVF = NUM_CH;
    // edge/level and mode-select codes
    localparam logic [1:0] EL_NONE = 2'h0;
    localparam logic [1:0] EL_RISE = 2'h1;
    localparam logic [1:0] EL_FALL = 2'h2;
    localparam logic [1:0] EL_BOTH = 2'h3;
    localparam logic [1:0] MS_CAPT = 2'h0;
    localparam logic [1:0] MS_COMP = 2'h1;
    typedef enum {CH_OFF, CH_CAPTURE, CH_COMPARE, CH_EPWM, CH_CPWM} ch_mode_t;
endpackage
